// ==== core/dcr_cal_clk_div.sv ====
// calibration clock divider off the converter clock
// assumes: clk is the converter clock, en and divSel from registers
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_cal_clk_div (
	input  wire logic       clk,    // converter clock
	input  wire logic       rst,    // sync reset, high
	input  wire logic       en,     // clock enable bit
	input  wire logic [2:0] divSel, // divide code
	output logic            cal_clock_enable, // divided clock level
	output logic            tick    // one pulse per period
);
	dcr_pkg::dcr_div_type s_q, s_d;

	// half period: 000 -> 128 (div 256) down to 111 -> 1 (div 2)
	function automatic logic [7:0] halfOf(input logic [2:0] sel);
		halfOf = 8'h80 >> sel;
	endfunction

	// count half periods, toggle, pulse on each rising level
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!en) begin
			s_d.cnt = 8'h00;
			s_d.clkLvl = 1'b0;
		end else if (s_q.cnt >= halfOf(divSel) - 8'h01) begin
			s_d.cnt = 8'h00;
			s_d.clkLvl = ~s_q.clkLvl;
			s_d.tick = ~s_q.clkLvl;
		end else begin
			s_d.cnt = s_q.cnt + 8'h01;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cal_clock_enable = s_q.clkLvl;
	assign tick   = s_q.tick;
endmodule

// ==== core/dcr_defines.svh ====
// register map, field positions, reset values and timing counts
// assumes: included by bare name wherever needed
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH
`define DCR_OFF_CALCTL   8'h0E
`define DCR_OFF_CALSTAT  8'h0F
`define DCR_OFF_MADDR    8'h10
`define DCR_OFF_MDATA    8'h11
`define DCR_OFF_MCMD     8'h12
`define DCR_OFF_RTCTL    8'h14
`define DCR_OFF_HWREV    8'h1F
// calibration control fields
`define DCR_B_QPRE       7
`define DCR_B_IPRE       6
`define DCR_B_QSEL       5
`define DCR_B_ISEL       4
`define DCR_B_CLKEN      3
// memory command fields
`define DCR_B_QCLR       7
`define DCR_B_ICLR       6
`define DCR_B_START      4
`define DCR_B_MWR        3
`define DCR_B_MRD        2
`define DCR_B_QUNCAL     1
`define DCR_B_IUNCAL     0
// retimer control fields
`define DCR_B_SEARCH     4
`define DCR_B_REACQ      3
`define DCR_B_OVR        2
// values
`define DCR_REF_FIXED    6'h20
`define DCR_REF_ADDR     6'h01
`define DCR_QBANK_BIT    5
`define DCR_COEF_DEFAULT 6'h00
`define DCR_ST_UNCAL     2'h0
`define DCR_ST_SELF      2'h1
`define DCR_ST_USER      2'h2
`define DCR_CAL_TICKS    8'h10
`define DCR_ACQ_MAX      8'h80
`define DCR_ACQ_CYCLES   8'h60
// arbitrary revision value
`define DCR_HW_REV       8'h01
`endif

// ==== core/dcr_pkg.sv ====
// types shared by the calibration and retimer register bank
// assumes: compiled before every other design file
package dcr_pkg;
	typedef enum logic [0:0] {
		CAL_IDLE = 1'b0,
		CAL_RUN  = 1'b1
	} dcr_cal_state_type;
	// one register write from the serial host
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} dcr_wr_type;
	typedef struct packed {
		logic [7:0] cnt;
		logic       clkLvl;
		logic       tick;
	} dcr_div_type;
	typedef struct packed {
		logic [1:0] iS1, iS2, qS1, qS2;
		logic [7:0] cnt;
		logic       searching;
		logic [1:0] iPh, qPh;
	} dcr_rt_type;
	typedef struct packed {
		logic [63:0][5:0]  mem;
		logic [7:0]        ctl;
		logic [5:0]        addr, data;
		logic              rtOvr, rtReacq, reacqPulse;
		logic [1:0]        rtForce;
		logic              qDone, iDone;
		logic [1:0]        qState, iState;
		dcr_cal_state_type calSt;
		logic              runQ, runI;
		logic [7:0]        calCnt;
		logic [7:0]        rdata;
		logic [5:0]        iRef, qRef;
		logic [1:0]        iPhUsed, qPhUsed;
	} dcr_regs_type;
endpackage

// ==== core/dcr_regs.sv ====
// calibration, coefficient memory and retimer control registers
// assumes: the serial host decoder presents one write per regWr.en
// Notes on behaviour
// - Q reference is fixed 32 unless Q preload select picks the user value
// - I reference is fixed 32 unless I preload select picks the user value
// - bits 5 and 4 select Q and I for self-calibration, either or both
// - calibration clock divides converter clock, runs only while enabled
// - divider code 000 gives 256, each step halves, 111 gives 2
// - done flags set when a channel finishes, cleared by writing one
// - status reports Q state in 3:2 and I state in 1:0
// - six-bit address register picks the coefficient location
// - six-bit data register carries write data and read results
// - writing one to bit 4 starts self-calibration of selected channels
// - writing one to bit 3 stores data register at the address
// - writing one to bit 2 loads the addressed word into data register
// - bits 1 and 0 restore Q and I coefficients to defaults
// - searching bit stays high while the retimer looks for its phase
// - a zero-to-one write of the reacquire bit restarts the search once
// - override makes the written I phase drive both retimers
// - I phase field reads the retimer choice, writable under override
// - Q retimer phase is read back in bits 7:6
// - read-only eight-bit hardware revision register
// - after reset the retimer locks within 128 cycles and drops searching
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_regs #(
	parameter logic [7:0] ACQ_CYCLES = `DCR_ACQ_CYCLES,
	parameter logic [7:0] CAL_TICKS  = `DCR_CAL_TICKS,
	parameter logic [7:0] HW_REV     = `DCR_HW_REV
) (
	input  wire logic                clk,        // converter clock
	input  wire logic                rst,        // sync reset, high
	input  wire dcr_pkg::dcr_wr_type regWr,      // host register write
	input  wire logic [7:0]          regRdAddr,  // host read address
	output logic [7:0]               regRdata,   // read data, one cycle late
	input  wire logic [1:0]          iDet,       // I phase detector
	input  wire logic [1:0]          qDet,       // Q phase detector
	output logic                     cal_clock_enable,     // calibration clock
	output logic                     searching,  // retimer searching
	output logic [5:0]               iRefValue,  // I calibration reference
	output logic [5:0]               qRefValue,  // Q calibration reference
	output logic [1:0]               iPhaseUsed, // I retimer phase in use
	output logic [1:0]               qPhaseUsed  // Q retimer phase in use
);
	// whole block state, registered once per clock
	dcr_pkg::dcr_regs_type s_q, s_d;
	logic       calTick;
	logic [1:0] rtI, rtQ;

	// write hit on one register offset
	function automatic logic hit(input dcr_pkg::dcr_wr_type w,
		input logic [7:0] off);
		hit = w.en && (w.addr == off);
	endfunction

	// decoded write strobes
	logic cmdWr, ctlWr, rtWr;
	assign cmdWr = hit(regWr, `DCR_OFF_MCMD);
	assign ctlWr = hit(regWr, `DCR_OFF_CALCTL);
	assign rtWr  = hit(regWr, `DCR_OFF_RTCTL);

	// calibration clock
	dcr_cal_clk_div u_div (
		.clk    (clk),
		.rst    (rst),
		.en     (s_q.ctl[`DCR_B_CLKEN]),
		.divSel (s_q.ctl[2:0]),
		.cal_clock_enable (cal_clock_enable),
		.tick   (calTick)
	);

	// phase acquisition
	dcr_retimer #(
		.ACQ_CYCLES (ACQ_CYCLES)
	) u_rt (
		.clk       (clk),
		.rst       (rst),
		.reacq     (s_q.reacqPulse),
		.iDet      (iDet),
		.qDet      (qDet),
		.searching (searching),
		.iPhase    (rtI),
		.qPhase    (rtQ)
	);

	// last calibration tick of a run
	logic calFinish;
	assign calFinish = (s_q.calSt == dcr_pkg::CAL_RUN) && calTick &&
		(s_q.calCnt == CAL_TICKS - 8'h01);

	// register writes, commands, calibration engine
	always_comb begin
		s_d = s_q;
		s_d.reacqPulse = 1'b0;
		if (ctlWr) begin
			s_d.ctl = regWr.data;
		end
		if (hit(regWr, `DCR_OFF_MADDR)) begin
			s_d.addr = regWr.data[5:0];
		end
		if (hit(regWr, `DCR_OFF_MDATA)) begin
			s_d.data = regWr.data[5:0];
		end
		// reacquire fires on a zero-to-one write only
		if (rtWr) begin
			s_d.rtReacq = regWr.data[`DCR_B_REACQ];
			s_d.reacqPulse = regWr.data[`DCR_B_REACQ] && !s_q.rtReacq;
			s_d.rtOvr = regWr.data[`DCR_B_OVR];
			if (regWr.data[`DCR_B_OVR]) begin
				s_d.rtForce = regWr.data[1:0];
			end
		end
		// commands are pulses from the write itself
		if (cmdWr && regWr.data[`DCR_B_MWR]) begin
			s_d.mem[s_q.addr] = s_q.data;
			if (s_q.addr[`DCR_QBANK_BIT]) begin
				s_d.qState = `DCR_ST_USER;
			end else begin
				s_d.iState = `DCR_ST_USER;
			end
		end
		if (cmdWr && regWr.data[`DCR_B_MRD]) begin
			s_d.data = s_q.mem[s_q.addr];
		end
		if (cmdWr && regWr.data[`DCR_B_QUNCAL]) begin
			for (int k = 32; k < 64; k++) begin
				s_d.mem[k] = `DCR_COEF_DEFAULT;
			end
			s_d.qState = `DCR_ST_UNCAL;
		end
		if (cmdWr && regWr.data[`DCR_B_IUNCAL]) begin
			for (int k = 0; k < 32; k++) begin
				s_d.mem[k] = `DCR_COEF_DEFAULT;
			end
			s_d.iState = `DCR_ST_UNCAL;
		end
		// calibration engine counts calibration clock periods
		case (s_q.calSt)
			dcr_pkg::CAL_IDLE: begin
				if (cmdWr && regWr.data[`DCR_B_START] &&
					(s_q.ctl[`DCR_B_QSEL] || s_q.ctl[`DCR_B_ISEL])) begin
					s_d.calSt = dcr_pkg::CAL_RUN;
					s_d.runQ = s_q.ctl[`DCR_B_QSEL];
					s_d.runI = s_q.ctl[`DCR_B_ISEL];
					s_d.calCnt = 8'h00;
				end
			end
			dcr_pkg::CAL_RUN: begin
				if (calFinish) begin
					s_d.calSt = dcr_pkg::CAL_IDLE;
					if (s_q.runQ) begin
						s_d.qState = `DCR_ST_SELF;
					end
					if (s_q.runI) begin
						s_d.iState = `DCR_ST_SELF;
					end
				end else if (calTick) begin
					s_d.calCnt = s_q.calCnt + 8'h01;
				end
			end
			default: begin
				s_d.calSt = dcr_pkg::CAL_IDLE;
			end
		endcase
		// done flags: a finish in the clearing cycle still sets
		s_d.qDone = (s_q.qDone && !(cmdWr && regWr.data[`DCR_B_QCLR])) ||
			(calFinish && s_q.runQ);
		s_d.iDone = (s_q.iDone && !(cmdWr && regWr.data[`DCR_B_ICLR])) ||
			(calFinish && s_q.runI);
		// references handed to the calibration engine
		s_d.qRef = s_q.ctl[`DCR_B_QPRE] ?
			s_q.mem[`DCR_REF_ADDR] : `DCR_REF_FIXED;
		s_d.iRef = s_q.ctl[`DCR_B_IPRE] ?
			s_q.mem[`DCR_REF_ADDR] : `DCR_REF_FIXED;
		// phases in use: forced value drives both retimers
		s_d.iPhUsed = s_q.rtOvr ? s_q.rtForce : rtI;
		s_d.qPhUsed = s_q.rtOvr ? s_q.rtForce : rtQ;
		// read mux, unmapped offsets read zero
		case (regRdAddr)
			`DCR_OFF_CALCTL: s_d.rdata = s_q.ctl;
			`DCR_OFF_CALSTAT: s_d.rdata = {s_q.qDone, s_q.iDone, 2'h0,
				s_q.qState, s_q.iState};
			`DCR_OFF_MADDR: s_d.rdata = {2'h0, s_q.addr};
			`DCR_OFF_MDATA: s_d.rdata = {2'h0, s_q.data};
			`DCR_OFF_MCMD: s_d.rdata = 8'h00;
			`DCR_OFF_RTCTL: s_d.rdata = {s_q.qPhUsed, 1'b0, searching,
				s_q.rtReacq, s_q.rtOvr, s_q.iPhUsed};
			`DCR_OFF_HWREV: s_d.rdata = HW_REV;
			default: s_d.rdata = 8'h00;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign regRdata   = s_q.rdata;
	assign iRefValue  = s_q.iRef;
	assign qRefValue  = s_q.qRef;
	assign iPhaseUsed = s_q.iPhUsed;
	assign qPhaseUsed = s_q.qPhUsed;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// reference selection, skipped in the reset cycle
	AST_QREF: assert property (
		!rst |=> qRefValue == ($past(s_q.ctl[7]) ? $past(s_q.mem[1]) : 6'h20))
		else $error("Q reference wrong");
	AST_IREF: assert property (
		!rst |=> iRefValue == ($past(s_q.ctl[6]) ? $past(s_q.mem[1]) : 6'h20))
		else $error("I reference wrong");
	AST_START: assert property (
		(cmdWr && regWr.data[4] && s_q.ctl[5] && s_q.calSt == dcr_pkg::CAL_IDLE)
		|=> s_q.calSt == dcr_pkg::CAL_RUN && s_q.runQ)
		else $error("self-calibration did not start");
	AST_DIVOFF: assert property (
		!s_q.ctl[3] ##1 !s_q.ctl[3] |=> !calTick && !cal_clock_enable)
		else $error("calibration clock runs while disabled");
	AST_QDONE: assert property (
		calFinish && s_q.runQ |=> s_q.qDone && s_q.qState == 2'h1)
		else $error("Q completion not flagged");
	AST_QCLR: assert property (
		cmdWr && regWr.data[7] && !calFinish |=> !s_q.qDone)
		else $error("Q completion not cleared");
	AST_MWR: assert property (
		cmdWr && regWr.data[3] && !regWr.data[1] && !regWr.data[0]
		|=> s_q.mem[$past(s_q.addr)] == $past(s_q.data))
		else $error("coefficient write lost");
	AST_MRD: assert property (
		cmdWr && regWr.data[2] && !regWr.data[3] |=> s_q.data == $past(s_q.mem[s_q.addr]))
		else $error("coefficient read wrong");
	AST_UNCAL: assert property (
		cmdWr && regWr.data[1] && !calFinish |=> s_q.qState == 2'h0 && s_q.mem[63] == 6'h00)
		else $error("Q restore failed");
	AST_REACQ: assert property (
		s_q.reacqPulse |=> searching ##1 !s_q.reacqPulse)
		else $error("reacquire did not restart search");
	AST_LOCK: assert property (
		$rose(searching) |-> ##[1:129] !searching)
		else $error("retimer did not lock in time");
	AST_OVR: assert property (
		s_q.rtOvr ##1 s_q.rtOvr |=> iPhaseUsed == qPhaseUsed)
		else $error("override not applied to both retimers");
	// field registers and read-only answers
	AST_ADDR: assert property (
		regWr.en && regWr.addr == `DCR_OFF_MADDR |=> s_q.addr == $past(regWr.data[5:0]))
		else $error("coefficient address not stored");
	AST_DATA: assert property (
		regWr.en && regWr.addr == `DCR_OFF_MDATA |=> s_q.data == $past(regWr.data[5:0]))
		else $error("coefficient data not stored");
	AST_RDADDR: assert property (
		regRdAddr == `DCR_OFF_MADDR |=> regRdata[7:6] == 2'h0)
		else $error("address readback upper bits set");
	AST_REV: assert property (
		regRdAddr == `DCR_OFF_HWREV |=> regRdata == HW_REV)
		else $error("revision readback wrong");
	AST_CMDRD: assert property (
		regRdAddr == `DCR_OFF_MCMD |=> regRdata == 8'h00)
		else $error("command register reads nonzero");
	AST_SEARCHRD: assert property (
		regRdAddr == `DCR_OFF_RTCTL |=> regRdata[`DCR_B_SEARCH] == $past(searching))
		else $error("searching readback wrong");
	// I channel calibration and restore
	AST_ISTART: assert property (
		(cmdWr && regWr.data[`DCR_B_START] && s_q.ctl[`DCR_B_ISEL] && s_q.calSt == dcr_pkg::CAL_IDLE)
		|=> s_q.calSt == dcr_pkg::CAL_RUN && s_q.runI)
		else $error("I self-calibration did not start");
	AST_NOSEL: assert property (
		(cmdWr && regWr.data[`DCR_B_START] && !s_q.ctl[`DCR_B_ISEL] && !s_q.ctl[`DCR_B_QSEL] &&
		s_q.calSt == dcr_pkg::CAL_IDLE) |=> s_q.calSt == dcr_pkg::CAL_IDLE)
		else $error("start with no channel selected was taken");
	AST_IDONE: assert property (
		calFinish && s_q.runI |=> s_q.iDone && s_q.iState == `DCR_ST_SELF)
		else $error("I completion not flagged");
	AST_ICLR: assert property (
		cmdWr && regWr.data[`DCR_B_ICLR] && !calFinish |=> !s_q.iDone)
		else $error("I completion not cleared");
	AST_IUNCAL: assert property (
		cmdWr && regWr.data[`DCR_B_IUNCAL] && !calFinish |=> s_q.iState == `DCR_ST_UNCAL && s_q.mem[0] == 6'h00)
		else $error("I restore failed");
	// retimer control
	AST_FORCE: assert property (
		rtWr && regWr.data[`DCR_B_OVR] |=> s_q.rtForce == $past(regWr.data[1:0]))
		else $error("forced phase not stored");
	AST_KEEP: assert property (
		rtWr && !regWr.data[`DCR_B_OVR] |=> $stable(s_q.rtForce))
		else $error("forced phase changed without override");
	AST_NOREACQ: assert property (
		rtWr && regWr.data[`DCR_B_REACQ] && s_q.rtReacq |=> !s_q.reacqPulse)
		else $error("reacquire fired without a rising write");

	// main scenarios reached
	COV_CAL: cover property (calFinish && s_q.runQ && s_q.runI);
	COV_REACQ: cover property (s_q.reacqPulse ##[1:200] $fell(searching));
	COV_OVR: cover property (rtWr && regWr.data[2]);
	COV_DIV2: cover property (calTick && s_q.ctl[2:0] == 3'h7);
	COV_QRESTORE: cover property (cmdWr && regWr.data[`DCR_B_QUNCAL]);
endmodule

// ==== core/dcr_retimer.sv ====
// retimer phase acquisition for I and Q
// assumes: phase detector inputs come from another clock domain
`timescale 1ns/1ps
`include "dcr_defines.svh"
module dcr_retimer #(
	parameter logic [7:0] ACQ_CYCLES = `DCR_ACQ_CYCLES
) (
	input  wire logic       clk,       // converter clock
	input  wire logic       rst,       // sync reset, high
	input  wire logic       reacq,     // restart search pulse
	input  wire logic [1:0] iDet,      // I phase detector
	input  wire logic [1:0] qDet,      // Q phase detector
	output logic            searching, // high while searching
	output logic [1:0]      iPhase,    // I acquired phase
	output logic [1:0]      qPhase     // Q acquired phase
);
	dcr_pkg::dcr_rt_type s_q, s_d;

	// synchronise detectors, count, then latch the phases
	always_comb begin
		s_d = s_q;
		s_d.iS1 = iDet;
		s_d.qS1 = qDet;
		s_d.iS2 = s_q.iS1;
		s_d.qS2 = s_q.qS1;
		if (reacq) begin
			s_d.searching = 1'b1;
			s_d.cnt = 8'h00;
		end else if (s_q.searching) begin
			if (s_q.cnt == ACQ_CYCLES - 8'h01) begin
				s_d.searching = 1'b0;
				s_d.iPh = s_q.iS2;
				s_d.qPh = s_q.qS2;
			end else begin
				s_d.cnt = s_q.cnt + 8'h01;
			end
		end
	end

	// state register, searching from reset
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.searching <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign searching = s_q.searching;
	assign iPhase    = s_q.iPh;
	assign qPhase    = s_q.qPh;
endmodule

// ==== dv/dcr_host_model.sv ====
// serial host model presenting register writes and reads
// assumes: design samples the parallel port on rising clk
`timescale 1ns/1ps
module dcr_host_model (
	input  wire logic           clk,       // converter clock
	output dcr_pkg::dcr_wr_type regWr,     // write request
	output logic [7:0]          regRdAddr, // read address
	input  wire logic [7:0]     regRdata   // read data
);
	// idle port at time zero
	initial begin
		regWr = '0;
		regRdAddr = 8'h00;
	end
	// one write pulse; released lines show the inverse, not the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= '{en: 1'b1, addr: a, data: d};
		@(posedge clk);
		regWr <= '{en: 1'b0, addr: ~a, data: ~d};
	endtask
	// address for one edge, data settled after the next
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regRdAddr <= a;
		@(posedge clk);
		#1 d = regRdata;
	endtask
endmodule

// ==== dv/dcr_regs_tb.sv ====
// self-checking bench of the calibration and retimer register bank
// assumes: host model drives the register port, bench drives detectors
`timescale 1ns/1ps
module dcr_regs_tb;
	localparam logic [7:0] REV = 8'h5A; // arbitrary revision value
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic [1:0]          iDet = 2'h2;
	logic [1:0]          qDet = 2'h1;
	dcr_pkg::dcr_wr_type regWr;
	logic [7:0]          regRdAddr;
	logic [7:0]          regRdata;
	logic [7:0]          rv;
	logic                cal_clock_enable;
	logic                searching;
	logic [5:0]          iRefValue;
	logic [5:0]          qRefValue;
	logic [1:0]          iPhaseUsed;
	logic [1:0]          qPhaseUsed;
	int                  miscompares = 0;
	int                  samplesChecked = 0;
	// short self-cal so completion comes quickly
	dcr_regs #(.CAL_TICKS(8'h02), .HW_REV(REV)) dut_u (
		.clk(clk), .rst(rst), .regWr(regWr), .regRdAddr(regRdAddr),
		.regRdata(regRdata), .iDet(iDet), .qDet(qDet), .cal_clock_enable(cal_clock_enable),
		.searching(searching), .iRefValue(iRefValue), .qRefValue(qRefValue),
		.iPhaseUsed(iPhaseUsed), .qPhaseUsed(qPhaseUsed));
	dcr_host_model host_u (.clk(clk), .regWr(regWr), .regRdAddr(regRdAddr), .regRdata(regRdata));
	// 8 ns clock
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samplesChecked++;
		if (s !== e) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// bounded wait for the retimer to lock
	task automatic wait_lock(output int n);
		n = 0;
		while (searching !== 1'b0 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic toggles(input int cyc, output int n);
		logic p;
		n = 0;
		#1;
		p = cal_clock_enable;
		repeat (cyc) begin
			@(posedge clk);
			#1;
			if (cal_clock_enable !== p) n++;
			p = cal_clock_enable;
		end
	endtask
	// lock time, revision is read-only, unmapped reads zero
	task automatic t_reset();
		int n;
		wait_lock(n);
		chk(8'(n <= 128), 8'h01);
		host_u.wr(8'h1F, 8'hFF);
		host_u.rd(8'h1F, rv);
		chk(rv, REV);
		host_u.rd(8'h13, rv);
		chk(rv, 8'h00);
	endtask
	// coefficient write, read back, preload and restore
	task automatic t_mem();
		host_u.wr(8'h10, 8'hC1);
		host_u.rd(8'h10, rv);
		chk(rv, 8'h01);
		host_u.wr(8'h11, 8'h2A);
		host_u.wr(8'h12, 8'h08);
		host_u.rd(8'h0F, rv);
		chk(rv, 8'h02);
		host_u.wr(8'h11, 8'h00);
		host_u.wr(8'h12, 8'h04);
		host_u.rd(8'h11, rv);
		chk(rv, 8'h2A);
		host_u.wr(8'h0E, 8'hC0);
		repeat (2) @(posedge clk);
		#1 chk({2'h0, iRefValue}, 8'h2A);
		chk({2'h0, qRefValue}, 8'h2A);
		host_u.wr(8'h0E, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk({2'h0, iRefValue}, 8'h20);
		chk({2'h0, qRefValue}, 8'h20);
		host_u.wr(8'h10, 8'h25);
		host_u.wr(8'h11, 8'h11);
		host_u.wr(8'h12, 8'h08);
		host_u.rd(8'h0F, rv);
		chk(rv, 8'h0A);
		host_u.wr(8'h12, 8'h01);
		host_u.rd(8'h0F, rv);
		chk(rv, 8'h08);
		host_u.wr(8'h10, 8'h01);
		host_u.wr(8'h12, 8'h04);
		host_u.rd(8'h11, rv);
		chk(rv, 8'h00);
		host_u.wr(8'h12, 8'h02);
		host_u.rd(8'h0F, rv);
		chk(rv, 8'h00);
		host_u.wr(8'h10, 8'h25);
		host_u.wr(8'h11, 8'h3F);
		host_u.rd(8'h11, rv);
		chk(rv, 8'h3F);
		host_u.wr(8'h12, 8'h04);
		host_u.rd(8'h11, rv);
		chk(rv, 8'h00);
	endtask
	// self-cal of both, flag clears, I alone, no clock no finish
	task automatic t_cal();
		host_u.wr(8'h0E, 8'h3F);
		host_u.wr(8'h12, 8'h10);
		repeat (20) @(posedge clk);
		host_u.rd(8'h0F, rv);
		chk(rv, 8'hC5);
		host_u.wr(8'h12, 8'h80);
		host_u.rd(8'h0F, rv);
		chk(rv, 8'h45);
		host_u.wr(8'h12, 8'h40);
		host_u.wr(8'h0E, 8'h1F);
		host_u.wr(8'h12, 8'h10);
		repeat (20) @(posedge clk);
		host_u.rd(8'h0F, rv);
		chk(rv, 8'h45);
		host_u.rd(8'h12, rv);
		chk(rv, 8'h00);
		host_u.wr(8'h12, 8'h40);
		host_u.wr(8'h0E, 8'h17);
		host_u.wr(8'h12, 8'h10);
		repeat (20) @(posedge clk);
		host_u.rd(8'h0F, rv);
		chk(rv, 8'h05);
	endtask
	// every divider code, then disabled
	task automatic t_div();
		int n;
		for (int c = 0; c < 8; c++) begin
			host_u.wr(8'h0E, {5'h01, 3'(c)});
			toggles(512, n);
			chk(8'(n >= (4 << c) - 1 && n <= (4 << c) + 1), 8'h01);
		end
		host_u.wr(8'h0E, 8'h07);
		repeat (4) @(posedge clk);
		toggles(64, n);
		chk(8'(n), 8'h00);
	endtask
	// readback, override, reacquire on edge only
	task automatic t_retime();
		int n;
		host_u.rd(8'h14, rv);
		chk(rv, 8'h42);
		host_u.wr(8'h14, 8'h07);
		repeat (2) @(posedge clk);
		#1 chk({4'h0, iPhaseUsed, qPhaseUsed}, 8'h0F);
		host_u.rd(8'h14, rv);
		chk(rv, 8'hC7);
		host_u.wr(8'h14, 8'h03);
		host_u.rd(8'h14, rv);
		chk(rv, 8'h42);
		host_u.wr(8'h14, 8'h08);
		@(posedge clk);
		iDet <= 2'h1;
		repeat (2) @(posedge clk);
		host_u.rd(8'h14, rv);
		chk(rv & 8'h10, 8'h10);
		wait_lock(n);
		chk(8'(n <= 128), 8'h01);
		host_u.rd(8'h14, rv);
		chk(rv, 8'h49);
		host_u.wr(8'h14, 8'h08);
		repeat (3) @(posedge clk);
		#1 chk({7'h0, searching}, 8'h00);
	endtask
	// reset for three cycles, then the scenarios
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_mem();
		t_cal();
		t_div();
		t_retime();
		end_of_test();
	end
	// watchdog well beyond the expected run
	initial begin
		repeat (30000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule
